/* src/pwm_pkg.sv */
/*
  Shared constants and types for the PWM core: register map, field
  positions, reset values, duty scaling and start-up timing.
  Assumes a single master clock at 50 MHz driving the whole core.
*/
package pwm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;      // mclk period
  localparam int MASTER_PERIOD_NS = 20;   // master_period, one mclk
  localparam int STARTUP_PERIODS = 500;   // startup_interval in master periods
  localparam int STARTUP_CYCLES = (STARTUP_PERIODS * MASTER_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CODE_DELAY_UNIT = 16;    // code_change_delay multiplier
  localparam int CODE_DELAY_OFFSET = 6;   // code_change_delay offset

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;

  // Control fields
  localparam int CTRL_DUTY_LSB = 0;
  localparam int DUTY_W = 11;
  localparam int CTRL_CLAMP_LO_BIT = 16;
  localparam int CTRL_CLAMP_HI_BIT = 17;
  localparam logic [10:0] CTRL_DUTY_RST = 11'h000;
  localparam logic CTRL_CLAMP_RST = 1'b0;

  // Status fields
  localparam int STATUS_CODE_LSB = 0;
  localparam int STATUS_INVERT_BIT = 4;
  localparam int STATUS_RUN_BIT = 8;
  localparam int STATUS_PWM_BIT = 9;
  localparam int STATUS_RESOLVED_BIT = 10;

  // ----------------------------------------------------------------
  // Duty scaling: 0x400 is full period
  // ----------------------------------------------------------------
  localparam int DUTY_FRAC_BITS = 10;
  localparam logic [10:0] DUTY_FULL = 11'h400;
  localparam logic [10:0] DUTY_CLAMP_LO = 11'h033;  // 5 percent
  localparam logic [10:0] DUTY_CLAMP_HI = 11'h3CD;  // 95 percent

  // Run state of the output stage
  typedef enum logic {ST_STARTUP, ST_RUN} run_state_t;

endpackage

/* src/code_filter.sv */
/*
  Divider-select code filter: synchronises the code pins and accepts a
  new code only after it has held still for the code change delay.
  Assumes the code pins are asynchronous to mclk.
*/
`timescale 1ns/10ps
module code_filter #(
  parameter int CODE_W = 4,
  parameter int CNT_W = 9
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Raw code from the converter
  input wire logic [CODE_W-1:0] code_pin,
  // Accepted code
  output logic [CODE_W-1:0] code,
  output logic resolved
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [CODE_W-1:0] s1_q, s2_q, s3_q;     // Synchroniser stages
  logic [CODE_W-1:0] cand_q, cand_d;       // Candidate code
  logic [CODE_W-1:0] code_q, code_d;       // Accepted code
  logic [CNT_W-1:0] cnt_q, cnt_d;          // Stability counter
  logic resolved_q, resolved_d;            // First code accepted
  logic [CODE_W-1:0] delta;                // Code difference
  logic [CNT_W-1:0] need;                  // Required stable cycles

  // Next-state logic of the filter
  always_comb begin
    delta = (cand_q >= code_q) ? cand_q - code_q : code_q - cand_q;
    // Initial resolve uses a zero difference
    if (!resolved_q) begin
      delta = '0;
    end
    need = CNT_W'((int'(delta) + pwm_pkg::CODE_DELAY_OFFSET) * pwm_pkg::CODE_DELAY_UNIT); // [R6]
    cand_d = cand_q;
    code_d = code_q;
    cnt_d = cnt_q;
    resolved_d = resolved_q;
    if (s2_q != s3_q) begin
      // Input still moving: restart the wait
      cnt_d = '0; // [R7]
    end else if (s3_q != cand_q) begin
      // New stable value: becomes the candidate
      cand_d = s3_q;
      cnt_d = '0;
    end else if (!resolved_q || cand_q != code_q) begin
      // Keep watching while running
      if (cnt_q == need - 1'b1) begin
        code_d = cand_q; // [R5] [R7]
        resolved_d = 1'b1;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // Registers; first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      cand_q <= '0;
      code_q <= '0;
      cnt_q <= '0;
      resolved_q <= 1'b0;
    end else begin
      s1_q <= code_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      cand_q <= cand_d;
      code_q <= code_d;
      cnt_q <= cnt_d;
      resolved_q <= resolved_d;
    end
  end

  assign code = code_q;
  assign resolved = resolved_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_code_jump: assert property ($changed(code_q) |-> code_q == $past(cand_q) && $past(s3_q) == code_q) // [R7]
    else $error("accepted code is not the stable candidate");
  chk_accept_delay: assert property ($changed(code_q) && $past(resolved_q) // [R6]
    |-> $past(cnt_q) == $past(need) - 1)
    else $error("code accepted after wrong delay");
  chk_keep_watch: assert property (resolved_q && s2_q == s3_q && s3_q == cand_q && cand_q != code_q // [R5]
    |-> ##[1:400] code_q == cand_q || $changed(cand_q) || s2_q != s3_q)
    else $error("stable new code never accepted");

endmodule

/* src/pwm_core.sv */
/*
  PWM core: duty command, clamps, output inversion, divider-select
  handling and the start-up interval, with an Avalon-MM slave.
  Assumes one 50 MHz master clock and asynchronous code pins.
*/
//
// Contract
// R1: Invert setting complements the PWM output
// R2: Inverted one-side clamps give mirrored ranges
// R3: Inversion moves single clamp to other end
// R4: Both-clamped keeps toggling; unclamped may rest (at ratio 1 the output rests even when both-clamped)
// R5: Keep sampling divider code while running
// R6: Accept code after 16 x (delta+6) cycles
// R7: Accept only stable code, no intermediate steps
// R8: Switch ratio and polarity without glitches
// R9: Output held low during start-up
// R10: Start-up lasts 500 cycles, any ratio
// R11: Resolve divider code before enabling output
// R12: Non-inverted first pulse has correct width
// R13: Inverted first pulse at least quarter period
// R14: Code sets divide ratio and inversion
// R15: Ratios 1 to 16384 by powers four
// R16: Clamps limit duty to 5..95 percent
// R17: Duty command is a sampled digital value
// R18: Compare, then clamp, then invert output
`timescale 1ns/10ps
module pwm_core #(
  parameter int CODE_W = 4,
  parameter int CNT_W = 15
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Divider select code pins
  input wire logic [CODE_W-1:0] divider_select_code,
  // PWM output pin
  output logic pwm_out
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Shift of the divide ratio; upper codes mirror the lower ones
  function automatic logic [3:0] shift_of(input logic [CODE_W-1:0] c);
    logic [2:0] idx;
    idx = c[3] ? ~c[2:0] : c[2:0]; // [R14] [R15]
    return {idx, 1'b0};
  endfunction

  // Divide ratio of a code
  function automatic logic [CNT_W-1:0] ratio_of(input logic [CODE_W-1:0] c);
    return CNT_W'(1) << shift_of(c); // [R15]
  endfunction

  // High-time threshold, before inversion
  function automatic logic [CNT_W-1:0] thr_of(
    input logic [10:0] duty,
    input logic lo,
    input logic hi,
    input logic [CODE_W-1:0] c
  );
    logic [10:0] d;
    logic [25:0] p;
    logic [CNT_W-1:0] r;
    logic [CNT_W-1:0] t;
    d = duty;
    // Saturate above full scale
    if (d > pwm_pkg::DUTY_FULL) begin
      d = pwm_pkg::DUTY_FULL;
    end
    // Clamps act on the non-inverted duty
    if (lo && d < pwm_pkg::DUTY_CLAMP_LO) begin
      d = pwm_pkg::DUTY_CLAMP_LO; // [R16]
    end
    if (hi && d > pwm_pkg::DUTY_CLAMP_HI) begin
      d = pwm_pkg::DUTY_CLAMP_HI; // [R16]
    end
    p = 26'(d) << shift_of(c); // [R17]
    t = p[pwm_pkg::DUTY_FRAC_BITS +: CNT_W];
    r = ratio_of(c);
    // Short periods: keep a clamped end from resting
    if (lo && t == '0 && r > CNT_W'(1)) begin
      t = CNT_W'(1); // [R4]
    end
    if (hi && t >= r && r > CNT_W'(1)) begin
      t = r - CNT_W'(1); // [R4]
    end
    return t;
  endfunction

  // ----------------------------------------------------------------
  // Divider code filter
  // ----------------------------------------------------------------
  logic [CODE_W-1:0] filt_code;  // Accepted code
  logic filt_resolved;           // First code resolved

  code_filter #(
    .CODE_W(CODE_W),
    .CNT_W(9)
  ) u_filter (
    .mclk(mclk),
    .rst_n(rst_n),
    .code_pin(divider_select_code),
    .code(filt_code),
    .resolved(filt_resolved)
  );

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [10:0] duty_q, duty_d;        // Duty command
  logic lo_q, lo_d;                   // Low clamp enable
  logic hi_q, hi_d;                   // High clamp enable
  logic ack_q, ack_d;                 // Second cycle of a request
  logic [31:0] rdata_q, rdata_d;      // Read data
  logic [31:0] ctrl_word;             // Control word as read
  logic [31:0] status_word;           // Status word as read
  logic [31:0] wmask;                 // Byte lane mask
  logic [31:0] ctrl_new;              // Control after a write

  // Output stage state, declared here for the status word
  pwm_pkg::run_state_t state_q, state_d;
  logic [8:0] start_cnt_q, start_cnt_d;   // Start-up counter
  logic [CNT_W-1:0] cnt_q, cnt_d;         // Period counter
  logic [CODE_W-1:0] code_q, code_d;      // Applied code
  logic [CNT_W-1:0] thr_q, thr_d;         // Applied threshold
  logic first_q, first_d;                 // First period flag
  logic pwm_q, pwm_d;                     // Output level
  logic running;                          // Start-up finished
  logic [CNT_W-1:0] cur_ratio;            // Applied divide ratio

  // Bus decode and register next values
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[pwm_pkg::CTRL_DUTY_LSB +: pwm_pkg::DUTY_W] = duty_q;
    ctrl_word[pwm_pkg::CTRL_CLAMP_LO_BIT] = lo_q;
    ctrl_word[pwm_pkg::CTRL_CLAMP_HI_BIT] = hi_q;
    status_word = 32'h0000_0000;
    status_word[pwm_pkg::STATUS_CODE_LSB +: CODE_W] = code_q;
    status_word[pwm_pkg::STATUS_INVERT_BIT] = code_q[3];
    status_word[pwm_pkg::STATUS_RUN_BIT] = running;
    status_word[pwm_pkg::STATUS_PWM_BIT] = pwm_q;
    status_word[pwm_pkg::STATUS_RESOLVED_BIT] = filt_resolved;
    wmask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    ctrl_new = (ctrl_word & ~wmask) | (writedata & wmask);
    // One wait state on every access
    ack_d = (read || write) && !ack_q;
    rdata_d = rdata_q;
    duty_d = duty_q;
    lo_d = lo_q;
    hi_d = hi_q;
    // Read data captured in the wait cycle
    if (read && !ack_q) begin
      if (address == pwm_pkg::CTRL_OFFSET) begin
        rdata_d = ctrl_word;
      end else if (address == pwm_pkg::STATUS_OFFSET) begin
        rdata_d = status_word;
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
    // Write lands when waitrequest is low
    if (write && ack_q) begin
      if (address == pwm_pkg::CTRL_OFFSET) begin
        duty_d = ctrl_new[pwm_pkg::CTRL_DUTY_LSB +: pwm_pkg::DUTY_W]; // [R17]
        lo_d = ctrl_new[pwm_pkg::CTRL_CLAMP_LO_BIT];
        hi_d = ctrl_new[pwm_pkg::CTRL_CLAMP_HI_BIT];
      end
    end
  end

  // Bus registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      duty_q <= pwm_pkg::CTRL_DUTY_RST;
      lo_q <= pwm_pkg::CTRL_CLAMP_RST;
      hi_q <= pwm_pkg::CTRL_CLAMP_RST;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      duty_q <= duty_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign waitrequest = (read || write) && !ack_q;
  assign readdata = rdata_q;

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] nxt_ratio;   // Ratio of the next cycle
  logic [CNT_W-1:0] first_thr;   // Rise point, first inverted period

  assign running = (state_q == pwm_pkg::ST_RUN);
  assign cur_ratio = ratio_of(code_q);

  // Start-up, period counting and output level
  always_comb begin
    state_d = state_q;
    start_cnt_d = start_cnt_q;
    cnt_d = cnt_q;
    code_d = code_q;
    thr_d = thr_q;
    first_d = first_q;
    pwm_d = 1'b0;
    case (state_q)
      pwm_pkg::ST_STARTUP: begin
        // Fixed interval, then wait for a resolved code
        if (start_cnt_q != 9'(pwm_pkg::STARTUP_CYCLES - 1)) begin
          start_cnt_d = start_cnt_q + 1'b1; // [R10]
        end else if (filt_resolved) begin
          state_d = pwm_pkg::ST_RUN; // [R11]
          code_d = filt_code;
          cnt_d = '0;
          thr_d = thr_of(duty_q, lo_q, hi_q, filt_code);
          first_d = 1'b1;
        end
      end
      default: begin
        // New code and duty only at a period boundary
        if (cnt_q == cur_ratio - 1'b1) begin
          cnt_d = '0;
          code_d = filt_code; // [R8]
          thr_d = thr_of(duty_q, lo_q, hi_q, filt_code);
          first_d = 1'b0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
    endcase
    nxt_ratio = ratio_of(code_d);
    first_thr = nxt_ratio - (nxt_ratio >> 2);
    if (thr_d < first_thr) begin
      first_thr = thr_d;
    end
    if (state_d == pwm_pkg::ST_RUN) begin
      if (first_d && code_d[3]) begin
        // Inverted first pulse: high for at least a quarter
        pwm_d = (cnt_d >= first_thr); // [R13]
      end else begin
        // Compare, then invert the clamped result
        pwm_d = (cnt_d < thr_d) ^ code_d[3]; // [R1] [R2] [R3] [R12] [R18]
      end
    end
  end

  // Output stage registers; output low out of reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pwm_pkg::ST_STARTUP;
      start_cnt_q <= 9'h000;
      cnt_q <= '0;
      code_q <= '0;
      thr_q <= '0;
      first_q <= 1'b0;
      pwm_q <= 1'b0; // [R9]
    end else begin
      state_q <= state_d;
      start_cnt_q <= start_cnt_d;
      cnt_q <= cnt_d;
      code_q <= code_d;
      thr_q <= thr_d;
      first_q <= first_d;
      pwm_q <= pwm_d;
    end
  end

  assign pwm_out = pwm_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Start of oscillation
  sequence run_begins;
    $rose(running);
  endsequence

  chk_startup_low: assert property (!running |-> !pwm_q) // [R9]
    else $error("output not low during start-up");
  chk_startup_len: assert property (run_begins |-> $past(start_cnt_q) == 9'(pwm_pkg::STARTUP_CYCLES - 1)) // [R10]
    else $error("start-up interval has wrong length");
  chk_resolve_first: assert property (run_begins |-> filt_resolved && code_q == $past(filt_code)) // [R11]
    else $error("output enabled before code resolved");
  chk_code_boundary: assert property ($changed(code_q) && $past(running) // [R8]
    |-> $past(cnt_q) == $past(cur_ratio) - 1 && cnt_q == '0)
    else $error("code applied mid-period");
  // Threshold judged against the clamps in force when it was loaded
  chk_both_toggle: assert property (running && $past(running) && cnt_q == '0 && $past(lo_q && hi_q) // [R4]
    && cur_ratio > 1 |-> thr_q != '0 && thr_q < cur_ratio)
    else $error("both-clamped output may rest");
  chk_invert_level: assert property (running && !first_q |-> pwm_q == ((cnt_q < thr_q) != code_q[3])) // [R1]
    else $error("output polarity wrong");
  chk_first_plain: assert property (run_begins ##0 !code_q[3] |-> pwm_q == (thr_q != '0)) // [R12]
    else $error("first non-inverted pulse wrong");
  chk_first_quarter: assert property (running && first_q && code_q[3] && cur_ratio >= 4 // [R13]
    && cnt_q >= cur_ratio - (cur_ratio >> 2) |-> pwm_q)
    else $error("first inverted pulse below a quarter period");
  chk_ratio_map: assert property (running // [R15]
    |-> cur_ratio == (CNT_W'(1) << (2 * (code_q[3] ? 15 - code_q : code_q))))
    else $error("divide ratio wrong for code");

endmodule

/* test/testbench.sv */
/*
  Self-checking bench for the PWM core: start-up hold, first pulse,
  register access, duty and clamp table, code filter and mid-run reset.
  Assumes pwm_core and pwm_pkg are compiled first; one 50 MHz clock.
*/
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0; // Master clock
  logic rst_n = 1'b0; // Async reset
  logic [3:0] address = 4'h0; // Bus address
  logic read = 1'b0; // Read request
  logic write = 1'b0; // Write request
  logic [31:0] writedata = 32'h0000_0000; // Write data
  logic [3:0] byteenable = 4'hf; // Byte lanes
  logic [31:0] readdata; // Read data
  logic waitrequest; // Bus stall
  logic [3:0] divider_select_code = 4'h1; // Code pins
  logic pwm_out; // PWM pin
  int n_mismatch = 0; // Mismatch count
  int num_checks = 0; // Comparison count
  int cyc = 0; // Timeout counter
  int n; // Run length scratch
  int cur; // Code on the pins
  logic [31:0] rd; // Read scratch
  // One table row: inputs, then high cycles per period and ratio
  typedef struct {logic [3:0] code; logic [10:0] duty; logic lo; logic hi; int high; int ratio;} row_t;
  row_t rows [16] = '{
    '{4'h1, 11'h200, 1'b0, 1'b0, 2, 4}, '{4'h1, 11'h000, 1'b0, 1'b0, 0, 4},
    '{4'h1, 11'h400, 1'b0, 1'b0, 4, 4}, '{4'h1, 11'h000, 1'b1, 1'b1, 1, 4},
    '{4'h1, 11'h400, 1'b1, 1'b1, 3, 4}, '{4'h1, 11'h000, 1'b1, 1'b0, 1, 4},
    '{4'h1, 11'h400, 1'b0, 1'b1, 3, 4}, '{4'he, 11'h000, 1'b1, 1'b0, 3, 4},
    '{4'he, 11'h400, 1'b1, 1'b0, 0, 4}, '{4'he, 11'h000, 1'b0, 1'b1, 4, 4},
    '{4'he, 11'h400, 1'b0, 1'b1, 1, 4}, '{4'hd, 11'h100, 1'b0, 1'b0, 12, 16},
    '{4'h2, 11'h300, 1'b0, 1'b0, 12, 16}, '{4'h2, 11'h000, 1'b1, 1'b1, 1, 16},
    '{4'h0, 11'h400, 1'b0, 1'b0, 1, 1}, '{4'hf, 11'h400, 1'b0, 1'b0, 0, 1}};

  // ----------------------------------------------------------------
  // Design and clock
  // ----------------------------------------------------------------
  pwm_core pwm_core_inst (.mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .divider_select_code(divider_select_code), .pwm_out(pwm_out));

  // Half period of 10 ns
  always #10 mclk = ~mclk;

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("Error at %0t ns: timeout", $time);
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Value compare
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t ns: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Window compare for counts with sync slack
  task chk_range(input int got, input int lo, input int hi, input string msg);
    num_checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("Error at %0t ns: %s got %0d outside %0d..%0d", $time, msg, got, lo, hi);
    end
  endtask

  // Bus write, held until waitrequest is seen low
  task bus_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= 1'b1;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    write <= 1'b0;
    @(posedge mclk);
  endtask

  // Bus read, data taken at the accepting edge
  task bus_read(input logic [3:0] a, output logic [31:0] d);
    address <= a;
    read <= 1'b1;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
    @(posedge mclk);
  endtask

  // Control word from duty and clamp bits
  task set_ctrl(input logic [10:0] duty, input logic lo, input logic hi);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[pwm_pkg::CTRL_DUTY_LSB +: pwm_pkg::DUTY_W] = duty;
    w[pwm_pkg::CTRL_CLAMP_LO_BIT] = lo;
    w[pwm_pkg::CTRL_CLAMP_HI_BIT] = hi;
    bus_write(pwm_pkg::CTRL_OFFSET, w, 4'hf);
  endtask

  // Cycles while the pin stays at one level
  task run_len(input logic lvl, input int max, output int cnt);
    cnt = 0;
    while (pwm_out === lvl && cnt < max) begin
      @(posedge mclk);
      cnt++;
    end
  endtask

  // Applied code, invert and running flags
  task chk_status(input logic [3:0] code);
    bus_read(pwm_pkg::STATUS_OFFSET, rd);
    chk({27'h0, rd[4:0]}, {27'h0, code[3], code}, "status code");
    chk({31'h0, rd[pwm_pkg::STATUS_RUN_BIT]}, 32'h0000_0001, "running");
    chk({31'h0, rd[pwm_pkg::STATUS_RESOLVED_BIT]}, 32'h0000_0001, "resolved");
  endtask

  // Test trailer
  task test_end(input string name);
    $display("Test %s done at %0t ns", name, $time);
  endtask

  // Counts, verdict and stop
  task end_sim();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int h;
    // Reset and start-up with ratio 4, half duty
    repeat (4) @(posedge mclk);
    chk({31'h0, pwm_out}, 32'h0000_0000, "pwm in reset");
    rst_n <= 1'b1;
    @(posedge mclk);
    set_ctrl(11'h200, 1'b0, 1'b0);
    run_len(1'b0, 700, n);
    chk_range(n + 4, 496, 510, "start-up length");
    run_len(1'b1, 40, n);
    chk(n, 2, "first pulse width");
    run_len(1'b0, 40, n);
    chk(n, 2, "first gap width");
    test_end("startup");

    // Register access
    bus_read(pwm_pkg::CTRL_OFFSET, rd);
    chk(rd, 32'h0000_0200, "ctrl readback");
    bus_write(pwm_pkg::CTRL_OFFSET, 32'h0003_07ff, 4'hf);
    bus_read(pwm_pkg::CTRL_OFFSET, rd);
    chk(rd, 32'h0003_07ff, "ctrl full write");
    bus_write(pwm_pkg::CTRL_OFFSET, 32'h0000_0000, 4'h1);
    bus_read(pwm_pkg::CTRL_OFFSET, rd);
    chk(rd, 32'h0003_0700, "ctrl byte lane");
    bus_write(pwm_pkg::STATUS_OFFSET, 32'hffff_ffff, 4'hf);
    chk_status(4'h1);
    bus_read(4'h8, rd);
    chk(rd, 32'h0000_0000, "unmapped read");
    test_end("registers");

    // Table of codes, duties and clamps
    cur = 1;
    foreach (rows[i]) begin
      divider_select_code <= rows[i].code;
      set_ctrl(rows[i].duty, rows[i].lo, rows[i].hi);
      repeat (16 * ((cur > rows[i].code ? cur - rows[i].code : rows[i].code - cur) + 6) + 80) @(posedge mclk);
      cur = rows[i].code;
      chk_status(rows[i].code);
      h = 0;
      repeat (4 * rows[i].ratio) begin
        @(posedge mclk);
        h += (pwm_out === 1'b1);
      end
      chk(h, 4 * rows[i].high, "high cycles");
    end
    test_end("table");

    // Unstable code is refused, then a clean step 15 to 12
    divider_select_code <= 4'hd;
    repeat (50) @(posedge mclk);
    divider_select_code <= 4'hc;
    chk_status(4'hf);
    repeat (127) @(posedge mclk);
    chk_status(4'hf);
    repeat (40) @(posedge mclk);
    chk_status(4'hc);
    test_end("code filter");

    // Second reset mid-run with inverted ratio 16
    divider_select_code <= 4'hd;
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({31'h0, pwm_out}, 32'h0000_0000, "pwm in second reset");
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    bus_read(pwm_pkg::CTRL_OFFSET, rd);
    chk(rd, 32'h0000_0000, "ctrl reset value");
    set_ctrl(11'h100, 1'b0, 1'b0);
    run_len(1'b0, 700, n);
    chk_range(n + 7, 496, 516, "restart length");
    run_len(1'b1, 40, n);
    chk(n, 12, "first inverted pulse");
    chk_range(n, 4, 16, "first inverted quarter");
    chk_status(4'hd);
    test_end("second reset");
    end_sim();
  end
endmodule
